//--- hdl/pcmap_pkg.sv
// Package with offsets, field positions and reset values of the I/O mapper
package pcmap_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned REG_AW = 12; // Register offset width
  localparam int unsigned REG_DW = 8; // Register data width
  localparam int unsigned IO_AW = 16; // Host and card I/O address width
  localparam int unsigned NUM_IO_WIN = 2; // I/O windows per socket
  localparam int unsigned NUM_MEM_WIN = 5; // Memory windows, decoded elsewhere

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [11:0] MAP_ENABLE_OFF = 12'h806; // Mapping enable
  localparam logic [11:0] IO_CTRL_OFF = 12'h807; // io_window_control
  // Per window offsets, index 1 in the upper slice
  localparam logic [1:0][11:0] START_LO_OFF = {12'h80c, 12'h808};
  localparam logic [1:0][11:0] START_HI_OFF = {12'h80d, 12'h809};
  localparam logic [1:0][11:0] END_LO_OFF = {12'h80e, 12'h80a};
  localparam logic [1:0][11:0] END_HI_OFF = {12'h80f, 12'h80b};
  localparam logic [1:0][11:0] OFFS_LO_OFF = {12'h838, 12'h836};
  localparam logic [1:0][11:0] OFFS_HI_OFF = {12'h839, 12'h837};

  // ****************************************************************
  // Field positions
  // ****************************************************************
  // Control bits per window: fixed size, auto size, timer select
  localparam int unsigned SIZE_BIT [2] = '{0, 4};
  localparam int unsigned AUTO_BIT [2] = '{1, 5};
  localparam int unsigned TSEL_BIT [2] = '{3, 7};
  // I/O enable bits in the mapping enable register
  localparam int unsigned EN_BIT [2] = '{6, 7};
  // Mapping enable bit that always reads zero
  localparam int unsigned EN_FIXED_BIT = 5;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] CTRL_RST = 8'h00; // Control reset value
  localparam logic [7:0] ENABLE_RST = 8'h00; // All windows off
  localparam logic [15:0] ADDR_RST = 16'h0000; // Start, end, offset
  localparam logic [7:0] READ_NONE = 8'h00; // Unmapped read data
  localparam logic [2:0] SYNC_RST = 3'h7; // Pin idles high

endpackage

//--- hdl/pcmap_io_window.sv
// I/O window decoder and address translator for one card socket
`timescale 1ns/1ns
`default_nettype none

// Function
// - Two I/O windows; the five memory windows are decoded elsewhere
// - Window 0 fixed width from bit 0
// - Bit 1 set: window 0 width from IOIS16
// - Bit 3 picks window 0 timer set
// - Window 1 width: bit 4, auto bit 5
// - Bit 7 picks window 1 timer set
// - Forward when address at or above start
// - End address from low, high bytes; inclusive
// - Card address is host plus offset
// - Offset bit 0 always treated as zero
// - Standard windows coexist with general windows
// - Window decodes only while enable bit set
module pcmap_io_window
  import pcmap_pkg::*;
(
  input wire logic clock, // 50 MHz system clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic reg_wr_en, // Register write strobe
  input wire logic reg_rd_en, // Register read strobe
  input wire logic [pcmap_pkg::REG_AW-1:0] reg_addr, // Register offset
  input wire logic [pcmap_pkg::REG_DW-1:0] reg_wdata, // Write data
  output logic [pcmap_pkg::REG_DW-1:0] reg_rdata, // Read data
  input wire logic host_io_req, // Host I/O access presented
  input wire logic [pcmap_pkg::IO_AW-1:0] host_io_addr, // Host address
  input wire logic card_iois16_n, // Card 16-bit I/O indication pin
  output logic map_valid, // Decode result pulse
  output logic map_hit, // Access claimed by a window
  output logic map_window, // Window that claimed it
  output logic [pcmap_pkg::IO_AW-1:0] card_io_addr, // Card I/O address
  output logic card_width16, // 16-bit card data path
  output logic timer_set1 // Timer set 1 selected
);
  import pcmap_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  // All state of the block in one record
  typedef struct packed {
    logic [7:0] ctrl; // I/O window control
    logic [7:0] map_en; // Mapping enable
    logic [1:0][15:0] start; // Window start addresses
    logic [1:0][15:0] stop; // Window end addresses, inclusive
    logic [1:0][15:0] offs; // Offsets as written
    logic [2:0] sync; // Pin synchroniser chain
    logic io16; // Filtered 16-bit indication
    logic [7:0] rdata; // Read data register
    logic valid; // Decode result pulse
    logic hit; // Window hit
    logic window; // Winning window
    logic [15:0] caddr; // Translated address
    logic wide; // 16-bit path
    logic tset; // Timer set
  } pcmap_state_t;

  pcmap_state_t q; // Current state
  pcmap_state_t d; // Next state
  logic [1:0] win_hit; // Per window decode
  logic [1:0][15:0] win_addr; // Per window translated address

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Width of a window: card indication when auto, else fixed bit
  function automatic logic win_wide(input logic [7:0] ctrl,
                                    input int unsigned w,
                                    input logic io16);
    if (ctrl[AUTO_BIT[w]])
      win_wide = io16;
    else
      win_wide = ctrl[SIZE_BIT[w]];
  endfunction

  // Register read decode
  function automatic logic [7:0] reg_read(input pcmap_state_t s,
                                          input logic [11:0] a);
    logic [7:0] r;
    r = READ_NONE;
    if (a == MAP_ENABLE_OFF)
    begin
      r = s.map_en;
      r[EN_FIXED_BIT] = 1'b0; // Fixed bit reads zero
    end
    if (a == IO_CTRL_OFF)
      r = s.ctrl;
    for (int w = 0; w < NUM_IO_WIN; w++)
    begin
      if (a == START_LO_OFF[w])
        r = s.start[w][7:0];
      if (a == START_HI_OFF[w])
        r = s.start[w][15:8];
      if (a == END_LO_OFF[w])
        r = s.stop[w][7:0];
      if (a == END_HI_OFF[w])
        r = s.stop[w][15:8];
      if (a == OFFS_LO_OFF[w])
        r = s.offs[w][7:0]; // Bit 0 kept for read back only
      if (a == OFFS_HI_OFF[w])
        r = s.offs[w][15:8];
    end
    reg_read = r;
  endfunction

  // ****************************************************************
  // Window decode
  // ****************************************************************
  // Both I/O windows decode side by side; memory windows live elsewhere
  generate
    for (genvar w = 0; w < NUM_IO_WIN; w++)
    begin : g_win
      // Range compare; start above end never matches
      assign win_hit[w] = q.map_en[EN_BIT[w]]
                          && (host_io_addr >= q.start[w])
                          && (host_io_addr <= q.stop[w]);
      // Offset with bit 0 forced low, sum wraps at 16 bits
      assign win_addr[w] = 16'(host_io_addr
                               + {q.offs[w][15:1], 1'b0});
    end
  endgenerate

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Register writes, pin filter and decode result
  always_comb
  begin
    d = q;
    d.valid = 1'b0;
    // Three stage pin sampling
    d.sync = {q.sync[1:0], card_iois16_n};
    // Accept a change once the last two stages agree
    if (q.sync[1] == q.sync[2])
      d.io16 = ~q.sync[2];
    // Software writes
    if (reg_wr_en)
    begin
      if (reg_addr == MAP_ENABLE_OFF)
        d.map_en = reg_wdata;
      if (reg_addr == IO_CTRL_OFF)
        d.ctrl = reg_wdata;
      for (int w = 0; w < NUM_IO_WIN; w++)
      begin
        if (reg_addr == START_LO_OFF[w])
          d.start[w][7:0] = reg_wdata;
        if (reg_addr == START_HI_OFF[w])
          d.start[w][15:8] = reg_wdata;
        if (reg_addr == END_LO_OFF[w])
          d.stop[w][7:0] = reg_wdata;
        if (reg_addr == END_HI_OFF[w])
          d.stop[w][15:8] = reg_wdata;
        if (reg_addr == OFFS_LO_OFF[w])
          d.offs[w][7:0] = reg_wdata;
        if (reg_addr == OFFS_HI_OFF[w])
          d.offs[w][15:8] = reg_wdata;
      end
    end
    // Read data is captured for the next cycle
    if (reg_rd_en)
      d.rdata = reg_read(q, reg_addr);
    // Host access: window 0 wins if both claim it
    if (host_io_req)
    begin
      d.valid = 1'b1;
      d.hit = |win_hit;
      if (win_hit[0])
      begin
        d.window = 1'b0;
        d.caddr = win_addr[0];
        d.wide = win_wide(q.ctrl, 0, q.io16);
        d.tset = q.ctrl[TSEL_BIT[0]];
      end
      else if (win_hit[1])
      begin
        d.window = 1'b1;
        d.caddr = win_addr[1];
        d.wide = win_wide(q.ctrl, 1, q.io16);
        d.tset = q.ctrl[TSEL_BIT[1]];
      end
      else
      begin
        // Miss: pass-through for general windows to claim
        d.window = 1'b0;
        d.caddr = host_io_addr;
        d.wide = 1'b0;
        d.tset = 1'b0;
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Register the record; reset loads constants only
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      q.ctrl <= CTRL_RST;
      q.map_en <= ENABLE_RST;
      q.start <= {ADDR_RST, ADDR_RST};
      q.stop <= {ADDR_RST, ADDR_RST};
      q.offs <= {ADDR_RST, ADDR_RST};
      q.sync <= SYNC_RST;
      q.io16 <= 1'b0;
      q.rdata <= READ_NONE;
      q.valid <= 1'b0;
      q.hit <= 1'b0;
      q.window <= 1'b0;
      q.caddr <= ADDR_RST;
      q.wide <= 1'b0;
      q.tset <= 1'b0;
    end
    else
      q <= d;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // All outputs straight from flip-flops
  assign reg_rdata = q.rdata;
  assign map_valid = q.valid;
  assign map_hit = q.hit;
  assign map_window = q.window;
  assign card_io_addr = q.caddr;
  assign card_width16 = q.wide;
  assign timer_set1 = q.tset;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Window 0 request sequence
  sequence s_req0;
    host_io_req && win_hit[0];
  endsequence

  // Window 1 only request sequence
  sequence s_req1;
    host_io_req && !win_hit[0] && win_hit[1];
  endsequence

  // Fixed width on window 0
  property p_w0_fixed;
    s_req0 ##0 !q.ctrl[1] |=> card_width16 == $past(q.ctrl[0]);
  endproperty
  a_w0_fixed: assert property (p_w0_fixed)
    else $error("window 0 fixed width wrong");

  // Auto width on window 0
  property p_w0_auto;
    s_req0 ##0 q.ctrl[1] |=> card_width16 == $past(q.io16);
  endproperty
  a_w0_auto: assert property (p_w0_auto)
    else $error("window 0 auto width wrong");

  // Timer set on window 0
  property p_w0_timer;
    s_req0 |=> map_valid && map_hit && !map_window
               && timer_set1 == $past(q.ctrl[3]);
  endproperty
  a_w0_timer: assert property (p_w0_timer)
    else $error("window 0 timer set wrong");

  // Width on window 1
  property p_w1_width;
    s_req1 |=> card_width16 == (($past(q.ctrl[5]))
                                ? $past(q.io16) : $past(q.ctrl[4]));
  endproperty
  a_w1_width: assert property (p_w1_width)
    else $error("window 1 width wrong");

  // Timer set on window 1
  property p_w1_timer;
    s_req1 |=> map_window && timer_set1 == $past(q.ctrl[7]);
  endproperty
  a_w1_timer: assert property (p_w1_timer)
    else $error("window 1 timer set wrong");

  // Hit only inside an enabled, ordered range
  property p_range;
    host_io_req |=> map_hit == $past(
      (q.map_en[6] && host_io_addr >= q.start[0]
       && host_io_addr <= q.stop[0])
      || (q.map_en[7] && host_io_addr >= q.start[1]
          && host_io_addr <= q.stop[1]));
  endproperty
  a_range: assert property (p_range)
    else $error("window hit decode wrong");

  // Translation with bit 0 of offset ignored, wrapping sum
  property p_xlate;
    s_req0 |=> card_io_addr == 16'($past(host_io_addr)
                 + {$past(q.offs[0][15:1]), 1'b0});
  endproperty
  a_xlate: assert property (p_xlate)
    else $error("card address translation wrong");

  // Card address keeps the host's bit 0 on every decode
  property p_bit0;
    host_io_req |=> card_io_addr[0] == $past(host_io_addr[0]);
  endproperty
  a_bit0: assert property (p_bit0)
    else $error("offset bit 0 leaked into address");

  // Miss passes the host address through for general windows
  property p_miss;
    host_io_req && !(|win_hit) |=> !map_hit && !map_window
      && card_io_addr == $past(host_io_addr)
      && !card_width16 && !timer_set1;
  endproperty
  a_miss: assert property (p_miss)
    else $error("miss result not passed through");

  // Result pulse only in the cycle after a request
  property p_pulse;
    map_valid && !$past(host_io_req) |-> 1'b0;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("decode pulse without request");

endmodule

`default_nettype wire

//--- dv/pcmap_card_model.sv
// Behavioural card that answers with its 16-bit I/O indication pin
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Card model
// ****************************************************************
module pcmap_card_model
(
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic io16_sel, // Card decodes a 16-bit port
  output logic card_iois16_n // Active low 16-bit indication
);
  // Pin follows the card decode one clock late and idles high
  always_ff @(posedge clock)
  begin
    if (rst)
      card_iois16_n <= 1'b1;
    else
      card_iois16_n <= ~io16_sel;
  end
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the I/O window mapper
`timescale 1ns/1ns
`default_nettype none

module testbench;
  import pcmap_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [11:0] ra = 12'h000;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdata;
  logic req = 1'b0;
  logic [15:0] ha = 16'h0000;
  logic io16 = 1'b0;
  logic pin_n;
  logic vld, hit, win, w16, t1;
  logic [15:0] ca;
  int err_total = 0;
  int n_compared = 0;

  // Clock at 50 MHz
  always #10 clock = ~clock;

  pcmap_io_window pcmap_io_window_i (.clock(clock), .rst(rst),
    .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(ra), .reg_wdata(wd),
    .reg_rdata(rdata), .host_io_req(req), .host_io_addr(ha),
    .card_iois16_n(pin_n), .map_valid(vld), .map_hit(hit),
    .map_window(win), .card_io_addr(ca), .card_width16(w16),
    .timer_set1(t1));
  pcmap_card_model pcmap_card_model_i (.clock(clock), .rst(rst),
    .io16_sel(io16), .card_iois16_n(pin_n));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Compare one value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One register write
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(negedge clock);
    wr = 1'b1;
    ra = a;
    wd = d;
    @(negedge clock);
    wr = 1'b0;
  endtask

  // One register read, data lands the cycle after the strobe
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    @(negedge clock);
    rd = 1'b1;
    ra = a;
    @(negedge clock);
    rd = 1'b0;
    chk({8'h00, rdata}, {8'h00, e});
  endtask

  // One host access and its decode result
  task automatic acc(input logic [15:0] a, input logic h, input logic w,
    input logic [15:0] c, input logic s, input logic t);
    @(negedge clock);
    req = 1'b1;
    ha = a;
    @(negedge clock);
    req = 1'b0;
    chk({15'h0, vld}, 16'h0001);
    chk({12'h0, hit, win, w16, t1}, {12'h0, h, w, s, t});
    chk(ca, c);
    @(negedge clock);
    chk({15'h0, vld}, 16'h0000);
    // Translated address stands until the next request
    chk(ca, c);
  endtask

  // Offset of byte k of window w
  function automatic logic [11:0] pick(input int w, input int k);
    logic [11:0] t [6];
    t = '{START_LO_OFF[w], START_HI_OFF[w], END_LO_OFF[w],
      END_HI_OFF[w], OFFS_LO_OFF[w], OFFS_HI_OFF[w]};
    return t[k];
  endfunction

  // Program start, end and offset of one window
  task automatic set_win(input int w, input logic [15:0] s, e, o);
    wr_reg(pick(w, 0), s[7:0]);
    wr_reg(pick(w, 1), s[15:8]);
    wr_reg(pick(w, 2), e[7:0]);
    wr_reg(pick(w, 3), e[15:8]);
    wr_reg(pick(w, 4), o[7:0]);
    wr_reg(pick(w, 5), o[15:8]);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset values, read back, fixed bit, unmapped place
  task automatic t_regs();
    logic [7:0] pat;
    rd_chk(IO_CTRL_OFF, 8'h00);
    rd_chk(MAP_ENABLE_OFF, 8'h00);
    for (int w = 0; w < 2; w++)
      for (int k = 0; k < 6; k++)
      begin
        pat = {1'b1, w[2:0], k[3:0]};
        rd_chk(pick(w, k), 8'h00);
        wr_reg(pick(w, k), pat);
        rd_chk(pick(w, k), pat);
      end
    wr_reg(IO_CTRL_OFF, 8'ha5);
    rd_chk(IO_CTRL_OFF, 8'ha5);
    wr_reg(MAP_ENABLE_OFF, 8'hff);
    rd_chk(MAP_ENABLE_OFF, 8'hdf);
    wr_reg(12'h800, 8'hff);
    rd_chk(12'h800, 8'h00);
  endtask

  // Every width and timer mode of both windows, pin both ways
  task automatic t_ctrl();
    logic [7:0] cv;
    // Stray low offset bit on window 0 must not move the card address
    set_win(0, 16'h0100, 16'h01ff, 16'h1001);
    set_win(1, 16'h0300, 16'h03ff, 16'hff00);
    wr_reg(MAP_ENABLE_OFF, 8'hc0);
    for (int w = 0; w < 2; w++)
      for (int c = 0; c < 8; c++)
        for (int p = 0; p < 2; p++)
        begin
          cv = 8'h00;
          cv[SIZE_BIT[w]] = c[0];
          cv[AUTO_BIT[w]] = c[1];
          cv[TSEL_BIT[w]] = c[2];
          wr_reg(IO_CTRL_OFF, cv);
          io16 = p[0];
          repeat (6) @(negedge clock);
          acc(w[0] ? 16'h0310 : 16'h0120, 1'b1, w[0],
            w[0] ? 16'h0210 : 16'h1120, c[1] ? p[0] : c[0],
            c[2]);
        end
  endtask

  // Edges of a window, disabled window, inverted window
  task automatic t_bounds();
    wr_reg(IO_CTRL_OFF, 8'h00);
    wr_reg(MAP_ENABLE_OFF, 8'h40);
    acc(16'h0100, 1'b1, 1'b0, 16'h1100, 1'b0, 1'b0);
    acc(16'h01ff, 1'b1, 1'b0, 16'h11ff, 1'b0, 1'b0);
    acc(16'h00ff, 1'b0, 1'b0, 16'h00ff, 1'b0, 1'b0);
    acc(16'h0200, 1'b0, 1'b0, 16'h0200, 1'b0, 1'b0);
    acc(16'h0310, 1'b0, 1'b0, 16'h0310, 1'b0, 1'b0);
    set_win(0, 16'h0200, 16'h01ff, 16'h0000);
    acc(16'h0200, 1'b0, 1'b0, 16'h0200, 1'b0, 1'b0);
    acc(16'h01ff, 1'b0, 1'b0, 16'h01ff, 1'b0, 1'b0);
  endtask

  // Mid-run reset clears registers and decode outputs
  task automatic t_reset();
    @(negedge clock);
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    chk({11'h0, vld, hit, win, w16, t1}, 16'h0000);
    chk(ca, 16'h0000);
    rd_chk(IO_CTRL_OFF, 8'h00);
    rd_chk(MAP_ENABLE_OFF, 8'h00);
    rd_chk(START_LO_OFF[0], 8'h00);
    acc(16'h0100, 1'b0, 1'b0, 16'h0100, 1'b0, 1'b0);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (5) @(negedge clock);
    rst = 1'b0;
    t_regs();
    t_ctrl();
    t_bounds();
    t_reset();
    stop_test();
  end
endmodule
`default_nettype wire
